// *** rtl/ioa_defines.svh ***
// offsets, field positions, reset values and code ranges of the incline block
// assumes 6-bit byte addresses carried in the serial command word
`ifndef IOA_DEFINES_SVH
`define IOA_DEFINES_SVH
// ==========================================
// byte addresses (even byte = bits 7:0), command codes and reset value
`define IOA_OFS_SUPPLY 6'h02
`define IOA_OFS_AUX 6'h08
`define IOA_OFS_TEMP 6'h0A
`define IOA_OFS_INCL 6'h0C
`define IOA_OFS_INCL_SIGNED 6'h0E
`define IOA_OFS_TRIM 6'h18
`define IOA_OFS_LIM1 6'h20
`define IOA_OFS_LIM2 6'h22
`define IOA_OFS_WIN1 6'h24
`define IOA_OFS_WIN2 6'h26
`define IOA_OFS_SETUP 6'h28
`define IOA_OFS_CMD 6'h3E
`define IOA_CMD_NULL 8'h01
`define IOA_CMD_RESTORE 8'h02
`define IOA_REG_RESET 16'h0000
// ==========================================
// alarm setup fields, source codes, limit direction and flag bit
`define IOA_SETUP_LINE 0
`define IOA_SETUP_POL 1
`define IOA_SETUP_EN 2
`define IOA_SETUP_FILT 4
`define IOA_SETUP_SEL 8
`define IOA_SETUP_SLOPE 11
`define IOA_CH_STRIDE 4
`define IOA_LIM_DIR 15
`define IOA_FLAG_BIT 14
`define IOA_SEL_SUPPLY 3'b001
`define IOA_SEL_AUX 3'b100
`define IOA_SEL_TEMP 3'b101
`define IOA_SEL_FULL 3'b110
`define IOA_SEL_SIGNED 3'b111
// ==========================================
// inclination code ranges and last serial bit index
`define IOA_HALF 16'sd7200
`define IOA_TURN 16'sd14400
`define IOA_TURN_HALF 16'sd21600
`define IOA_TWO_TURNS 16'sd28800
`define IOA_LAST_BIT 5'd15
`endif

// *** rtl/ioa_pkg.sv ***
// types shared by the incline offset and alarm block
// assumes ioa_defines.svh for all numeric constants
package ioa_pkg;
  // ==========================================
  // sensor words, 12-bit sources sit in bits 11:0
  typedef struct packed {
    logic [13:0] supply;
    logic [13:0] aux;
    logic [13:0] temp;
    logic [13:0] incl;
    logic [13:0] incl_signed;
  } ioa_src_type;
  // two auxiliary lines, oe_n low = driven
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] oe_n;
  } ioa_pins_type;
  typedef enum logic {SPI_IDLE, SPI_SHIFT} ioa_spi_type;
  // ==========================================
  // whole state of the core
  typedef struct packed {
    ioa_spi_type spi;
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [4:0] bit_cnt;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic [5:0] rd_addr;
    logic miso;
    logic [15:0] trim;
    logic [1:0][15:0] limit;
    logic [1:0][15:0] window;
    logic [15:0] setup;
    logic [1:0][13:0] ref_val;
    logic [1:0][7:0] cnt;
    logic [1:0] alarm;
    ioa_pins_type pins;
  } ioa_state_type;
endpackage

// *** rtl/ioa_core.sv ***
// incline offset trim, two alarm channels and serial register port
// assumes sensor words and strobe on REF_CLK; serial pins are asynchronous
`timescale 1ns/10ps
`include "ioa_defines.svh"
module ioa_core (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  input wire logic SAMPLE_STROBE,
  input ioa_pkg::ioa_src_type INST_DATA,
  input ioa_pkg::ioa_src_type FILT_DATA,
  input ioa_pkg::ioa_pins_type MISC_LINES,
  input ioa_pkg::ioa_pins_type GPIO_LINES,
  output ioa_pkg::ioa_pins_type AUX_LINES
);
  // ==========================================
  // helpers
  function automatic logic [13:0] wrap_full(input logic [13:0] v, input logic [13:0] t);
    logic [15:0] s;
    s = {2'b00, v} + {2'b00, t};
    if (s >= `IOA_TWO_TURNS) s = s - `IOA_TWO_TURNS;
    else if (s >= `IOA_TURN) s = s - `IOA_TURN;
    return s[13:0];
  endfunction

  function automatic logic [13:0] wrap_signed(input logic [13:0] v, input logic [13:0] t);
    logic signed [15:0] s;
    s = 16'($signed(v)) + $signed({2'b00, t});
    if (s >= `IOA_TURN_HALF) s = s - `IOA_TWO_TURNS;
    else if (s >= `IOA_HALF) s = s - `IOA_TURN;
    else if (s < -`IOA_HALF) s = s + `IOA_TURN;
    return s[13:0];
  endfunction

  function automatic ioa_pkg::ioa_src_type apply_trim(input ioa_pkg::ioa_src_type d,
                                                      input logic [13:0] t);
    ioa_pkg::ioa_src_type r;
    r = d;
    r.incl = wrap_full(d.incl, t);
    r.incl_signed = wrap_signed(d.incl_signed, t);
    return r;
  endfunction

  function automatic logic [13:0] pick(input logic [2:0] sel, input ioa_pkg::ioa_src_type d);
    case (sel)
      `IOA_SEL_SUPPLY: pick = d.supply;
      `IOA_SEL_AUX: pick = d.aux;
      `IOA_SEL_TEMP: pick = d.temp;
      `IOA_SEL_FULL: pick = d.incl;
      `IOA_SEL_SIGNED: pick = d.incl_signed;
      default: pick = '0;
    endcase
  endfunction

  function automatic logic [15:0] wr_byte(input logic [15:0] old, input logic hi,
                                          input logic [7:0] d);
    return hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  function automatic logic [15:0] read_word(input logic [5:0] a,
                                            input ioa_pkg::ioa_state_type s,
                                            input ioa_pkg::ioa_src_type d);
    logic f;
    f = |s.alarm;
    case ({a[5:1], 1'b0})
      `IOA_OFS_SUPPLY: read_word = {1'b0, f, d.supply};
      `IOA_OFS_AUX: read_word = {1'b0, f, d.aux};
      `IOA_OFS_TEMP: read_word = {1'b0, f, d.temp};
      `IOA_OFS_INCL: read_word = {1'b0, f, d.incl};
      `IOA_OFS_INCL_SIGNED: read_word = {1'b0, f, d.incl_signed};
      `IOA_OFS_TRIM: read_word = s.trim;
      `IOA_OFS_LIM1: read_word = s.limit[0];
      `IOA_OFS_LIM2: read_word = s.limit[1];
      `IOA_OFS_WIN1: read_word = s.window[0];
      `IOA_OFS_WIN2: read_word = s.window[1];
      `IOA_OFS_SETUP: read_word = s.setup;
      default: read_word = '0;
    endcase
  endfunction

  // ==========================================
  // state
  ioa_pkg::ioa_state_type st;
  ioa_pkg::ioa_state_type next_st;
  ioa_pkg::ioa_src_type filt_t;
  ioa_pkg::ioa_src_type inst_t;
  logic sck_rise;
  logic sck_fall;
  logic [15:0] spi_word;
  logic [5:0] spi_addr;
  logic [7:0] spi_data;
  logic spi_wr;
  logic cmd_null;
  logic cmd_restore;
  logic [13:0] null_val;
  logic any_alarm;

  assign filt_t = apply_trim(FILT_DATA, st.trim[13:0]);
  assign inst_t = apply_trim(INST_DATA, st.trim[13:0]);
  assign sck_rise = st.sck_s[1] & ~st.sck_s[2];
  assign sck_fall = ~st.sck_s[1] & st.sck_s[2];
  assign spi_word = {st.sh_in[14:0], st.mosi_s[1]};
  assign spi_addr = spi_word[13:8];
  assign spi_data = spi_word[7:0];
  assign null_val = (FILT_DATA.incl == 14'h0000) ? 14'h0000
                    : 14'(`IOA_TURN - $signed({2'b00, FILT_DATA.incl}));
  assign any_alarm = |st.alarm;

  // ==========================================
  // next state
  always_comb begin
    logic [2:0] sel;
    logic sgn;
    logic [13:0] val;
    logic signed [23:0] cur;
    logic signed [23:0] lim;
    logic signed [23:0] delta;
    logic [7:0] win;
    logic [8:0] cnt_up;
    sel = '0;
    sgn = 1'b0;
    val = '0;
    cur = '0;
    lim = '0;
    delta = '0;
    win = '0;
    cnt_up = '0;
    next_st = st;
    spi_wr = 1'b0;
    cmd_null = 1'b0;
    cmd_restore = 1'b0;
    next_st.sck_s = {st.sck_s[1:0], SCLK};
    next_st.cs_s = {st.cs_s[1:0], CS_N};
    next_st.mosi_s = {st.mosi_s[0], MOSI};
    // serial frame: 16 bits, msb first, sampled on rising clock edge
    unique case (st.spi)
      ioa_pkg::SPI_IDLE: begin
        if (!st.cs_s[1]) begin
          next_st.spi = ioa_pkg::SPI_SHIFT;
          next_st.bit_cnt = '0;
          next_st.sh_out = read_word(st.rd_addr, st, filt_t);
        end
      end
      ioa_pkg::SPI_SHIFT: begin
        if (st.cs_s[1]) begin
          next_st.spi = ioa_pkg::SPI_IDLE;
        end else if (sck_rise) begin
          next_st.sh_in = spi_word;
          next_st.bit_cnt = st.bit_cnt + 5'd1;
          if (st.bit_cnt == `IOA_LAST_BIT) begin
            next_st.bit_cnt = '0;
            if (spi_word[15]) spi_wr = 1'b1;
            else next_st.rd_addr = spi_addr;
          end
        end else if (sck_fall) begin
          next_st.miso = st.sh_out[15];
          next_st.sh_out = {st.sh_out[14:0], 1'b0};
        end
      end
    endcase
    // byte writes
    if (spi_wr) begin
      case ({spi_addr[5:1], 1'b0})
        `IOA_OFS_TRIM: next_st.trim = wr_byte(st.trim, spi_addr[0], spi_data);
        `IOA_OFS_LIM1: next_st.limit[0] = wr_byte(st.limit[0], spi_addr[0], spi_data);
        `IOA_OFS_LIM2: next_st.limit[1] = wr_byte(st.limit[1], spi_addr[0], spi_data);
        `IOA_OFS_WIN1: if (!spi_addr[0]) next_st.window[0] = {8'h00, spi_data};
        `IOA_OFS_WIN2: if (!spi_addr[0]) next_st.window[1] = {8'h00, spi_data};
        `IOA_OFS_SETUP: next_st.setup = wr_byte(st.setup, spi_addr[0], spi_data);
        `IOA_OFS_CMD: begin
          cmd_null = !spi_addr[0] && spi_data == `IOA_CMD_NULL;
          cmd_restore = !spi_addr[0] && spi_data == `IOA_CMD_RESTORE;
        end
        default: ;
      endcase
    end
    if (cmd_null) next_st.trim = {2'b00, null_val};
    if (cmd_restore) next_st.trim = `IOA_REG_RESET;
    // alarm channels
    for (int i = 0; i < 2; i++) begin
      sel = st.setup[`IOA_SETUP_SEL + `IOA_CH_STRIDE * i +: 3];
      sgn = sel == `IOA_SEL_SIGNED;
      val = st.setup[`IOA_SETUP_FILT + i] ? pick(sel, filt_t) : pick(sel, inst_t);
      cur = sgn ? 24'($signed(val)) : 24'($signed({1'b0, val}));
      lim = sgn ? 24'($signed(st.limit[i][13:0])) : 24'($signed({1'b0, st.limit[i][13:0]}));
      win = (st.window[i][7:0] == 8'h00) ? 8'h01 : st.window[i][7:0];
      cnt_up = {1'b0, st.cnt[i]} + 9'd1;
      if (!(sel inside {`IOA_SEL_SUPPLY, `IOA_SEL_AUX, `IOA_SEL_TEMP, `IOA_SEL_FULL,
                        `IOA_SEL_SIGNED})) begin
        next_st.alarm[i] = 1'b0;
        next_st.cnt[i] = '0;
        next_st.ref_val[i] = val;
      end else if (SAMPLE_STROBE) begin
        if (!st.setup[`IOA_SETUP_SLOPE + `IOA_CH_STRIDE * i]) begin
          next_st.alarm[i] = st.limit[i][`IOA_LIM_DIR] ? cur > lim : cur < lim;
          next_st.cnt[i] = '0;
          next_st.ref_val[i] = val;
        end else if (cnt_up >= {1'b0, win}) begin
          delta = cur - (sgn ? 24'($signed(st.ref_val[i]))
                             : 24'($signed({1'b0, st.ref_val[i]})));
          lim = 24'($signed(st.limit[i][13:0])) * 24'($signed({1'b0, win}));
          next_st.alarm[i] = st.limit[i][`IOA_LIM_DIR] ? delta > lim : delta < lim;
          next_st.cnt[i] = '0;
          next_st.ref_val[i] = val;
        end else begin
          next_st.cnt[i] = cnt_up[7:0];
        end
      end
    end
    // auxiliary lines
    for (int i = 0; i < 2; i++) begin
      if (!MISC_LINES.oe_n[i]) begin
        next_st.pins.level[i] = MISC_LINES.level[i];
        next_st.pins.oe_n[i] = 1'b0;
      end else if (st.setup[`IOA_SETUP_EN] && st.setup[`IOA_SETUP_LINE] == i[0]) begin
        next_st.pins.level[i] = st.setup[`IOA_SETUP_POL] ? any_alarm : !any_alarm;
        next_st.pins.oe_n[i] = 1'b0;
      end else begin
        next_st.pins.level[i] = GPIO_LINES.level[i];
        next_st.pins.oe_n[i] = GPIO_LINES.oe_n[i];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.sck_s <= 3'h7;
      st.cs_s <= 3'h7;
      st.pins.oe_n <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign MISO = st.miso;
  assign AUX_LINES = st.pins;

  // ==========================================
  // checks
  property p_byte;
    @(posedge REF_CLK) disable iff (!RST_N)
    spi_wr && spi_addr == `IOA_OFS_TRIM |=>
      st.trim[15:8] == $past(st.trim[15:8]) && st.trim[7:0] == $past(spi_data);
  endproperty
  a_byte: assert property (p_byte) else $error("low byte write disturbed high byte");

  property p_null;
    @(posedge REF_CLK) disable iff (!RST_N)
    cmd_null ##1 $stable(FILT_DATA.incl) |-> filt_t.incl == 14'h0000;
  endproperty
  a_null: assert property (p_null) else $error("null did not zero the output");

  property p_restore;
    @(posedge REF_CLK) disable iff (!RST_N)
    cmd_restore |=> st.trim == `IOA_REG_RESET && filt_t.incl == FILT_DATA.incl;
  endproperty
  a_restore: assert property (p_restore) else $error("restore left a trim");

  property p_range;
    @(posedge REF_CLK) disable iff (!RST_N)
    FILT_DATA.incl < 14'(`IOA_TURN) |-> filt_t.incl < 14'(`IOA_TURN);
  endproperty
  a_range: assert property (p_range) else $error("trimmed output out of range");

  property p_flag;
    @(posedge REF_CLK) disable iff (!RST_N)
    any_alarm |-> |(read_word(`IOA_OFS_INCL, st, filt_t) & (16'h0001 << `IOA_FLAG_BIT)) &&
                  |(read_word(`IOA_OFS_SUPPLY, st, filt_t) & (16'h0001 << `IOA_FLAG_BIT));
  endproperty
  a_flag: assert property (p_flag) else $error("alarm flag missing");

  property p_pin;
    @(posedge REF_CLK) disable iff (!RST_N)
    st.setup[`IOA_SETUP_EN] && !st.setup[`IOA_SETUP_LINE] && MISC_LINES.oe_n[0] |=>
      !AUX_LINES.oe_n[0] &&
      AUX_LINES.level[0] == ($past(st.setup[`IOA_SETUP_POL]) ~^ $past(any_alarm));
  endproperty
  a_pin: assert property (p_pin) else $error("alarm line wrong");

  property p_misc;
    @(posedge REF_CLK) disable iff (!RST_N)
    !MISC_LINES.oe_n[1] |=> !AUX_LINES.oe_n[1] && AUX_LINES.level[1] == $past(MISC_LINES.level[1]);
  endproperty
  a_misc: assert property (p_misc) else $error("misc claim lost");

  property p_off;
    @(posedge REF_CLK) disable iff (!RST_N)
    st.setup[10:8] == 3'b000 |=> !st.alarm[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled alarm active");

  property p_thr;
    @(posedge REF_CLK) disable iff (!RST_N)
    SAMPLE_STROBE && st.setup[11:8] == {1'b0, `IOA_SEL_FULL} && !st.setup[`IOA_SETUP_FILT] &&
      st.limit[0][`IOA_LIM_DIR] && inst_t.incl > st.limit[0][13:0] |=> st.alarm[0];
  endproperty
  a_thr: assert property (p_thr) else $error("threshold alarm missed");

  property p_win;
    @(posedge REF_CLK) disable iff (!RST_N)
    st.setup[`IOA_SETUP_SLOPE] && st.window[0][7:0] != 8'h00 |-> st.cnt[0] < st.window[0][7:0];
  endproperty
  a_win: assert property (p_win) else $error("slope window overrun");
endmodule

// *** verif/ioa_host_model.sv ***
// serial host model: frames, reads, trim writes and the null sequence
// assumes mode 3 framing, 200 ns link clock, core on REF_CLK
`timescale 1ns/10ps
`include "ioa_defines.svh"
module ioa_host_model (
  input wire logic REF_CLK,
  input wire logic SAMPLE_STROBE,
  output logic SCLK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO
);
  initial begin
    SCLK = 1'b1;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // ====================
  // one frame, msb first, reply taken on each rise
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge REF_CLK);
    #1;
    CS_N = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      SCLK = 1'b0;
      MOSI = w[i];
      #100;
      SCLK = 1'b1;
      r[i] = MISO;
      #100;
    end
    CS_N = 1'b1;
    MOSI = ~MOSI;
    #400;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    xfer({2'b10, a, d}, r);
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    logic [15:0] r;
    xfer({2'b00, a, 8'h00}, r);
    xfer(16'h0000, v);
  endtask
  // ====================
  // trim write, top bits forced to zero
  task automatic wr_trim(input logic [13:0] t);
    wr(`IOA_OFS_TRIM, t[7:0]);
    wr(6'h19, {2'b00, t[13:8]});
  endtask
  // deep averaging, 512 samples, null, restore
  task automatic autonull(input logic [7:0] prev);
    int n;
    n = 0;
    wr(6'h38, 8'h08);
    while (n < 32'h200) begin
      @(posedge REF_CLK);
      if (SAMPLE_STROBE === 1'b1) n++;
    end
    wr(`IOA_OFS_CMD, `IOA_CMD_NULL);
    wr(6'h38, prev);
  endtask
endmodule

// *** verif/incline_offset_and_alarm_logic_tb_top.sv ***
// bench for the incline trim and alarm core
// assumes ioa_host_model on the serial port, strobes from the bench
`timescale 1ns/10ps
`include "ioa_defines.svh"
module incline_offset_and_alarm_logic_tb_top;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SAMPLE_STROBE = 1'b0;
  logic SCLK;
  logic CS_N;
  logic MOSI;
  logic MISO;
  ioa_pkg::ioa_src_type INST_DATA = {5{14'h0064}};
  ioa_pkg::ioa_src_type FILT_DATA = {42'h0, 14'h36B0, 14'h3F9C};
  ioa_pkg::ioa_pins_type MISC_LINES = 4'h3;
  ioa_pkg::ioa_pins_type GPIO_LINES = 4'hC;
  ioa_pkg::ioa_pins_type AUX_LINES;
  int errors = 0;
  int total_checks = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  ioa_core dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
    .MOSI(MOSI), .MISO(MISO), .SAMPLE_STROBE(SAMPLE_STROBE),
    .INST_DATA(INST_DATA), .FILT_DATA(FILT_DATA), .MISC_LINES(MISC_LINES),
    .GPIO_LINES(GPIO_LINES), .AUX_LINES(AUX_LINES));
  ioa_host_model host (.REF_CLK(REF_CLK), .SAMPLE_STROBE(SAMPLE_STROBE),
    .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO));
  // ====================
  // shared helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic al(input logic e);
    chk({15'h0000, AUX_LINES.level[0]}, {15'h0000, e});
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge REF_CLK);
      SAMPLE_STROBE <= 1'b1;
      @(posedge REF_CLK);
      SAMPLE_STROBE <= 1'b0;
      repeat (3) @(posedge REF_CLK);
    end
  endtask
  // ====================
  // scenarios
  task automatic t_reset;
    rdc(`IOA_OFS_TRIM, 16'h0000);
    rdc(`IOA_OFS_LIM1, 16'h0000);
    rdc(`IOA_OFS_INCL, 16'h36B0);
    chk({12'h000, AUX_LINES}, 16'h000C);
  endtask
  task automatic t_bytes;
    host.wr_trim(14'h1234);
    rdc(`IOA_OFS_TRIM, 16'h1234);
    host.wr(6'h19, 8'h05);
    rdc(6'h19, 16'h0534);
    rdc(`IOA_OFS_INCL, 16'h03A4);
    rdc(`IOA_OFS_INCL_SIGNED, 16'h04D0);
  endtask
  task automatic t_cmd;
    @(posedge REF_CLK);
    FILT_DATA.incl <= 14'h1388;
    fork
      host.autonull(8'h00);
      strobe(600);
    join
    rdc(`IOA_OFS_TRIM, 16'h24B8);
    rdc(`IOA_OFS_INCL, 16'h0000);
    host.wr(`IOA_OFS_CMD, `IOA_CMD_RESTORE);
    rdc(`IOA_OFS_TRIM, 16'h0000);
  endtask
  task automatic t_src;
    logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    @(posedge REF_CLK);
    FILT_DATA <= {5{14'h03E8}};
    host.wr(`IOA_OFS_LIM1, 8'hF4);
    host.wr(6'h21, 8'h81);
    host.wr(`IOA_OFS_SETUP, 8'h16);
    foreach (codes[i]) begin
      host.wr(6'h29, {5'h00, codes[i]});
      strobe(1);
      chk({12'h000, AUX_LINES},
          {12'h000, 1'b1, !(codes[i] inside {3'h0, 3'h2, 3'h3}), 2'b00});
    end
    rdc(`IOA_OFS_TEMP, 16'h43E8);
    rdc(`IOA_OFS_SUPPLY, 16'h43E8);
  endtask
  task automatic t_mode;
    host.wr(`IOA_OFS_SETUP, 8'h06);
    strobe(1);
    chk({12'h000, AUX_LINES}, 16'h0008);
    host.wr(6'h21, 8'h01);
    host.wr(`IOA_OFS_SETUP, 8'h05);
    strobe(1);
    chk({12'h000, AUX_LINES}, 16'h0004);
    MISC_LINES <= 4'h9;
    repeat (3) @(posedge REF_CLK);
    chk({12'h000, AUX_LINES}, 16'h000C);
    MISC_LINES <= 4'h3;
    host.wr(6'h29, 8'h06);
    host.wr(6'h21, 8'h81);
    @(posedge REF_CLK);
    INST_DATA.incl <= 14'h0320;
    strobe(1);
    chk({12'h000, AUX_LINES}, 16'h0004);
  endtask
  task automatic t_slope;
    host.wr(`IOA_OFS_SETUP, 8'h16);
    host.wr(6'h29, 8'h0E);
    host.wr(`IOA_OFS_WIN1, 8'h02);
    host.wr(`IOA_OFS_LIM1, 8'h0A);
    host.wr(6'h21, 8'h80);
    strobe(4);
    al(1'b0);
    FILT_DATA.incl <= 14'h03F7;
    strobe(2);
    al(1'b0);
    FILT_DATA.incl <= 14'h045B;
    strobe(2);
    al(1'b1);
  endtask
  task automatic t_two;
    host.wr(6'h29, 8'h10);
    host.wr(`IOA_OFS_LIM2, 8'hF4);
    host.wr(6'h23, 8'h81);
    host.wr(`IOA_OFS_SETUP, 8'h26);
    strobe(1);
    al(1'b1);
    host.wr(6'h29, 8'h50);
    host.wr(6'h23, 8'h00);
    strobe(1);
    al(1'b0);
    host.wr(6'h29, 8'h70);
    host.wr(6'h23, 8'h80);
    host.wr(`IOA_OFS_LIM2, 8'h32);
    @(posedge REF_CLK);
    FILT_DATA.incl_signed <= 14'h3F9C;
    strobe(1);
    al(1'b0);
  endtask
  // ====================
  // verdict and run control
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    t_reset();
    t_bytes();
    t_cmd();
    t_src();
    t_mode();
    t_slope();
    t_two();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge REF_CLK);
    errors++;
    print_verdict();
  end
endmodule
